// ---- inc/pepc_pkg.sv ----
// Constants and types for the PCI error and power event control block
// Functional notes
// - An address parity error drives the system error line low for exactly one clock.
// - Data parity errors are reported for every transaction type except special cycles.
// - The parity error line goes active two data clocks after the errored data phase; the block drives it three clocks after.
// - The parity error line stays active at least one clock per errored data phase.
// - The parity error line is sustained tri-state: driven low, then driven high, then released.
// - While power good is low the block holds its reset state and floats every PCI signal.
// - A wake event pulls the power event line low if either wake enable bit is 1.
// - Auxiliary power present high means D3cold is supported, low means no auxiliary power.
// - The LAN-disable strap reading 1 enables the device and reading 0 disables it.
// - The strap is sampled within 1 us after both power good and PCI reset have risen.
// - The flash serial input carries an internal pull-up so the strap reads high unfitted.
// - During PCI reset all PCI outputs but the power event line float and inputs are ignored.
// - Most internal state is reset on the rising edge of PCI reset.
package pepc_pkg;

  // Register byte offsets
  localparam logic [7:0] PEPC_WAKE_CTRL_OFS = 8'h00;
  localparam logic [7:0] PEPC_STATUS_OFS = 8'h04;
  localparam logic [7:0] PEPC_INFO_OFS = 8'h08;
  localparam logic [7:0] PEPC_ERRCNT_OFS = 8'h0c;

  // Wake control fields
  localparam int PEPC_CTRL_PME_EN_BIT = 0;
  localparam int PEPC_CTRL_ADV_EN_BIT = 1;
  localparam logic [1:0] PEPC_CTRL_RST = 2'h0;

  // Status fields, write one to clear
  localparam int PEPC_ST_WAKE_BIT = 0;
  localparam int PEPC_ST_APERR_BIT = 1;
  localparam int PEPC_ST_DPERR_BIT = 2;
  localparam logic [2:0] PEPC_STATUS_RST = 3'h0;

  // Info fields, read only
  localparam int PEPC_INFO_LAN_EN_BIT = 0;
  localparam int PEPC_INFO_STRAP_OK_BIT = 1;
  localparam int PEPC_INFO_AUX_BIT = 2;
  localparam int PEPC_INFO_PME_BIT = 3;
  localparam int PEPC_INFO_PGOOD_BIT = 4;
  localparam int PEPC_INFO_PCIRST_BIT = 5;

  // Error counters, data parity in high half
  localparam int PEPC_CNT_W = 16;
  localparam int PEPC_CNT_DP_LSB = 16;

  // Timing
  localparam int PEPC_PERR_DELAY_CYC = 2;
  localparam int PEPC_CLK_MHZ = 250;
  localparam int PEPC_STRAP_WINDOW_NS = 1000;
  localparam int PEPC_STRAP_WINDOW_CYC = (PEPC_STRAP_WINDOW_NS * PEPC_CLK_MHZ) / 1000;
  localparam logic [7:0] PEPC_STRAP_SAMPLE_CNT = 8'(PEPC_STRAP_WINDOW_CYC - 2);
  localparam logic PEPC_LAN_EN_RST = 1'b1;

  typedef enum logic [2:0] {
    PEPC_STRAP_WAIT = 3'b001,
    PEPC_STRAP_COUNT = 3'b010,
    PEPC_STRAP_DONE = 3'b100
  } pepc_strap_state_t;

endpackage

// ---- rtl/pepc_perr_pipe.sv ----
// Delay line placing a data parity report a fixed number of clocks later
`timescale 1ns/1ps
`default_nettype none
module pepc_perr_pipe (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  // Error per data phase
  input wire logic phase_err_in,
  output logic report_out
);
  logic [pepc_pkg::PEPC_PERR_DELAY_CYC-1:0] stage_reg;

  genvar i;
  generate
    for (i = 0; i < pepc_pkg::PEPC_PERR_DELAY_CYC; i++) begin : g_stage
      always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
          stage_reg[i] <= 1'b0;
        end else if (clear_in) begin
          stage_reg[i] <= 1'b0;
        end else if (i == 0) begin
          stage_reg[i] <= phase_err_in;
        end else begin
          stage_reg[i] <= stage_reg[(i == 0) ? 0 : i-1];
        end
      end
    end
  endgenerate

  // One stage bit per phase keeps back-to-back errors asserted
  assign report_out = stage_reg[pepc_pkg::PEPC_PERR_DELAY_CYC-1];
endmodule
`default_nettype wire

// ---- rtl/pepc_strap.sv ----
// LAN-disable strap sampler on the shared flash data input
`timescale 1ns/1ps
`default_nettype none
module pepc_strap (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Power and PCI reset levels
  input wire logic power_good_in,
  input wire logic pci_rst_n_in,
  // Shared strap pin
  input wire logic flash_serial_in,
  // Result
  output logic lan_enable_out,
  output logic strap_valid_out
);
  pepc_pkg::pepc_strap_state_t state_reg;
  logic [7:0] cnt_reg;
  logic both_up;

  assign both_up = power_good_in & pci_rst_n_in;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= pepc_pkg::PEPC_STRAP_WAIT;
      cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        pepc_pkg::PEPC_STRAP_WAIT: begin
          cnt_reg <= 8'h00;
          if (both_up) begin
            state_reg <= pepc_pkg::PEPC_STRAP_COUNT;
          end
        end
        pepc_pkg::PEPC_STRAP_COUNT: begin
          if (!both_up) begin
            state_reg <= pepc_pkg::PEPC_STRAP_WAIT;
          end else if (cnt_reg == pepc_pkg::PEPC_STRAP_SAMPLE_CNT) begin
            state_reg <= pepc_pkg::PEPC_STRAP_DONE;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        pepc_pkg::PEPC_STRAP_DONE: begin
          if (!both_up) begin
            state_reg <= pepc_pkg::PEPC_STRAP_WAIT;
          end
        end
        default: begin
          state_reg <= pepc_pkg::PEPC_STRAP_WAIT;
        end
      endcase
    end
  end

  // Late sample gives the pin time to settle, still inside the window
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lan_enable_out <= pepc_pkg::PEPC_LAN_EN_RST;
    end else if (state_reg == pepc_pkg::PEPC_STRAP_COUNT && both_up
                 && cnt_reg == pepc_pkg::PEPC_STRAP_SAMPLE_CNT) begin
      lan_enable_out <= flash_serial_in;
    end
  end

  assign strap_valid_out = (state_reg == pepc_pkg::PEPC_STRAP_DONE);
endmodule
`default_nettype wire

// ---- rtl/pepc_top.sv ----
// PCI error reporting, power event and strap control with APB registers
`timescale 1ns/1ps
`default_nettype none
module pepc_top (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // System levels
  input wire logic power_good_in,
  input wire logic pci_rst_n_in,
  input wire logic aux_power_present_in,
  // Events from the PCI core
  input wire logic addr_parity_err_in,
  input wire logic data_phase_in,
  input wire logic data_parity_err_in,
  input wire logic special_cycle_in,
  input wire logic wake_event_in,
  // Strap pin
  input wire logic flash_serial_in,
  output logic flash_pullup_en_out,
  // Open-drain system error
  output logic serr_n_out,
  output logic serr_oe_out,
  // Sustained tri-state parity error
  output logic perr_n_out,
  output logic perr_oe_out,
  // Open-drain power event
  output logic pme_n_out,
  output logic pme_oe_out,
  // Device state
  output logic pci_float_out,
  output logic core_reset_out,
  output logic lan_enable_out,
  output logic d3cold_support_out
);
  logic [1:0] wake_control_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [pepc_pkg::PEPC_CNT_W-1:0] aperr_cnt_reg;
  logic [pepc_pkg::PEPC_CNT_W-1:0] dperr_cnt_reg;
  logic pci_rst_n_d_reg;
  logic aux_reg;
  logic serr_pulse_reg;
  logic perr_drive_reg;
  logic perr_park_reg;
  logic pme_active_reg;
  logic pci_rst_rise;
  logic core_clear;
  logic inputs_live;
  logic ap_err;
  logic dp_err;
  logic perr_report;
  logic strap_valid;
  logic apb_setup;
  logic apb_write;
  logic addr_hit;
  logic [31:0] rdata_next;

  // Reset control
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pci_rst_n_d_reg <= 1'b0;
    end else begin
      pci_rst_n_d_reg <= pci_rst_n_in;
    end
  end

  assign pci_rst_rise = pci_rst_n_in & ~pci_rst_n_d_reg;
  // Power good low holds the core in reset
  assign core_clear = ~power_good_in | pci_rst_rise;
  assign core_reset_out = ~power_good_in;
  // PCI pins float in reset or without power
  assign pci_float_out = ~power_good_in | ~pci_rst_n_in;
  // Inputs are ignored while in either reset
  assign inputs_live = power_good_in & pci_rst_n_in;

  // Qualified error events
  assign ap_err = inputs_live & addr_parity_err_in;
  assign dp_err = inputs_live & data_phase_in & data_parity_err_in
                  & ~special_cycle_in;

  // System error pulse
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      serr_pulse_reg <= 1'b0;
    end else if (core_clear | ~pci_rst_n_in) begin
      serr_pulse_reg <= 1'b0;
    end else begin
      serr_pulse_reg <= ap_err & ~serr_pulse_reg;
    end
  end

  assign serr_n_out = 1'b0;
  assign serr_oe_out = serr_pulse_reg;

  // Parity error delay line
  pepc_perr_pipe u_perr_pipe (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .clear_in(core_clear),
    .phase_err_in(dp_err),
    .report_out(perr_report)
  );

  // Drive low, then drive high one clock before releasing
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      perr_drive_reg <= 1'b0;
      perr_park_reg <= 1'b0;
    end else if (core_clear | ~pci_rst_n_in) begin
      perr_drive_reg <= 1'b0;
      perr_park_reg <= 1'b0;
    end else begin
      perr_drive_reg <= perr_report;
      perr_park_reg <= perr_drive_reg & ~perr_report;
    end
  end

  assign perr_n_out = ~perr_drive_reg;
  assign perr_oe_out = perr_drive_reg | perr_park_reg;

  // Strap sampling
  pepc_strap u_strap (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .power_good_in(power_good_in),
    .pci_rst_n_in(pci_rst_n_in),
    .flash_serial_in(flash_serial_in),
    .lan_enable_out(lan_enable_out),
    .strap_valid_out(strap_valid)
  );

  // Pull-up always on so an empty flash site reads enabled
  assign flash_pullup_en_out = 1'b1;

  // Auxiliary power level
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aux_reg <= 1'b0;
    end else begin
      aux_reg <= aux_power_present_in;
    end
  end

  assign d3cold_support_out = aux_reg;

  // APB decode, zero wait states
  assign apb_setup = psel_in & ~penable_in;
  assign apb_write = psel_in & penable_in & pwrite_in;
  assign addr_hit = (paddr_in == pepc_pkg::PEPC_WAKE_CTRL_OFS)
                    | (paddr_in == pepc_pkg::PEPC_STATUS_OFS)
                    | (paddr_in == pepc_pkg::PEPC_INFO_OFS)
                    | (paddr_in == pepc_pkg::PEPC_ERRCNT_OFS);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_hit;

  // Wake enables survive PCI reset, cleared only without power
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wake_control_reg <= pepc_pkg::PEPC_CTRL_RST;
    end else if (!power_good_in) begin
      wake_control_reg <= pepc_pkg::PEPC_CTRL_RST;
    end else if (apb_write && paddr_in == pepc_pkg::PEPC_WAKE_CTRL_OFS) begin
      wake_control_reg <= pwdata_in[1:0];
    end
  end

  // Sticky status, a new event beats a clear in the same cycle
  always_comb begin
    status_next = status_reg;
    if (apb_write && paddr_in == pepc_pkg::PEPC_STATUS_OFS) begin
      status_next = status_reg & ~pwdata_in[2:0];
    end
    if (pci_rst_rise) begin
      status_next[pepc_pkg::PEPC_ST_APERR_BIT] = 1'b0;
      status_next[pepc_pkg::PEPC_ST_DPERR_BIT] = 1'b0;
    end
    if (wake_event_in) begin
      status_next[pepc_pkg::PEPC_ST_WAKE_BIT] = 1'b1;
    end
    if (ap_err) begin
      status_next[pepc_pkg::PEPC_ST_APERR_BIT] = 1'b1;
    end
    if (dp_err) begin
      status_next[pepc_pkg::PEPC_ST_DPERR_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_reg <= pepc_pkg::PEPC_STATUS_RST;
    end else if (!power_good_in) begin
      status_reg <= pepc_pkg::PEPC_STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  // Error counters saturate rather than wrap
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aperr_cnt_reg <= '0;
      dperr_cnt_reg <= '0;
    end else if (core_clear) begin
      aperr_cnt_reg <= '0;
      dperr_cnt_reg <= '0;
    end else if (apb_write && paddr_in == pepc_pkg::PEPC_ERRCNT_OFS) begin
      aperr_cnt_reg <= '0;
      dperr_cnt_reg <= '0;
    end else begin
      if (ap_err && aperr_cnt_reg != '1) begin
        aperr_cnt_reg <= aperr_cnt_reg + 16'h0001;
      end
      if (dp_err && dperr_cnt_reg != '1) begin
        dperr_cnt_reg <= dperr_cnt_reg + 16'h0001;
      end
    end
  end

  // Power event line, held until status or both enables clear
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pme_active_reg <= 1'b0;
    end else begin
      pme_active_reg <= power_good_in & status_next[pepc_pkg::PEPC_ST_WAKE_BIT]
                        & (wake_control_reg[pepc_pkg::PEPC_CTRL_PME_EN_BIT]
                        | wake_control_reg[pepc_pkg::PEPC_CTRL_ADV_EN_BIT]);
    end
  end

  // Not floated by PCI reset, only by loss of power
  assign pme_n_out = 1'b0;
  assign pme_oe_out = pme_active_reg & power_good_in;

  // Read data captured in the setup cycle
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr_in)
      pepc_pkg::PEPC_WAKE_CTRL_OFS: begin
        rdata_next[1:0] = wake_control_reg;
      end
      pepc_pkg::PEPC_STATUS_OFS: begin
        rdata_next[2:0] = status_reg;
      end
      pepc_pkg::PEPC_INFO_OFS: begin
        rdata_next[pepc_pkg::PEPC_INFO_LAN_EN_BIT] = lan_enable_out;
        rdata_next[pepc_pkg::PEPC_INFO_STRAP_OK_BIT] = strap_valid;
        rdata_next[pepc_pkg::PEPC_INFO_AUX_BIT] = aux_reg;
        rdata_next[pepc_pkg::PEPC_INFO_PME_BIT] = pme_active_reg;
        rdata_next[pepc_pkg::PEPC_INFO_PGOOD_BIT] = power_good_in;
        rdata_next[pepc_pkg::PEPC_INFO_PCIRST_BIT] = ~pci_rst_n_in;
      end
      pepc_pkg::PEPC_ERRCNT_OFS: begin
        rdata_next = {dperr_cnt_reg, aperr_cnt_reg};
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_out <= rdata_next;
    end
  end
endmodule
`default_nettype wire

// ---- verif/pepc_host_model.sv ----
// System-side model of the shared flash data line and strap driver
`timescale 1ns/1ps
`default_nettype none
module pepc_host_model (
  // Clock
  input wire logic clk_sys_in,
  // Flash part and strap driver
  input wire logic flash_fitted_in,
  input wire logic flash_bit_in,
  input wire logic strap_drive_in,
  input wire logic strap_val_in,
  // Pin pull-up from the block
  input wire logic flash_pullup_en_in,
  output logic flash_serial_out
);
  logic junk_reg = 1'b0;

  // Undriven, unpulled line must not look settled
  always @(posedge clk_sys_in) begin
    junk_reg <= !junk_reg;
  end

  always_comb begin
    if (flash_fitted_in) begin
      flash_serial_out = flash_bit_in;
    end else if (strap_drive_in) begin
      flash_serial_out = strap_val_in;
    end else if (flash_pullup_en_in) begin
      flash_serial_out = 1'b1;
    end else begin
      flash_serial_out = junk_reg;
    end
  end
endmodule
`default_nettype wire

// ---- verif/pepc_top_properties.sv ----
// Port-level checks for the PCI error and power event block
`timescale 1ns/1ps
`default_nettype none
module pepc_top_properties (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // APB writes
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  // Levels and events
  input wire logic power_good_in,
  input wire logic pci_rst_n_in,
  input wire logic aux_power_present_in,
  input wire logic addr_parity_err_in,
  input wire logic data_phase_in,
  input wire logic data_parity_err_in,
  input wire logic special_cycle_in,
  input wire logic wake_event_in,
  input wire logic flash_serial_in,
  // Outputs watched
  input wire logic serr_oe_out,
  input wire logic perr_n_out,
  input wire logic perr_oe_out,
  input wire logic pme_oe_out,
  input wire logic lan_enable_out,
  input wire logic d3cold_support_out
);
  logic [1:0] en_reg;
  logic wr;
  logic live;
  logic derr;

  assign wr = psel_in && penable_in && pwrite_in;
  assign live = power_good_in && pci_rst_n_in;
  assign derr = data_phase_in && data_parity_err_in && !special_cycle_in;

  // Shadow of the wake enables, so the wake checks know the mode
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      en_reg <= 2'h0;
    end else if (!power_good_in) begin
      en_reg <= 2'h0;
    end else if (wr && paddr_in == pepc_pkg::PEPC_WAKE_CTRL_OFS) begin
      en_reg <= pwdata_in[1:0];
    end
  end

  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  AST_SERR_START: assert property (
    addr_parity_err_in && live && $past(pci_rst_n_in) && !serr_oe_out |=> serr_oe_out)
    else $error("serr pulse missing");
  AST_SERR_ONE: assert property (
    serr_oe_out |=> !serr_oe_out) else $error("serr longer than one clock");
  AST_PERR_DELAY: assert property (
    derr && live && $past(pci_rst_n_in) ##1 live [*3] |-> perr_oe_out && !perr_n_out)
    else $error("perr not low in time");
  AST_PERR_CAUSE: assert property (
    perr_oe_out && !perr_n_out |-> $past(derr, 3)) else $error("perr without cause");
  AST_PERR_RELEASE: assert property (
    $fell(perr_oe_out) && $past(live) |-> $past(perr_n_out))
    else $error("perr released while low");
  AST_PG_LOW: assert property (
    !power_good_in [*2] |-> !serr_oe_out && !perr_oe_out && !pme_oe_out)
    else $error("pin driven without power");
  AST_RST_QUIET: assert property (
    !pci_rst_n_in [*2] |-> !serr_oe_out && !perr_oe_out)
    else $error("error pin driven in reset");
  AST_PME_SET: assert property (
    wake_event_in && power_good_in && en_reg != 2'h0 && !wr |=> pme_oe_out || !power_good_in)
    else $error("pme missing");
  AST_PME_HOLD: assert property (
    pme_oe_out && !wr && !$past(wr) ##1 power_good_in |-> pme_oe_out)
    else $error("pme dropped early");
  AST_D3COLD: assert property (
    $past(resetn_in) |-> d3cold_support_out == $past(aux_power_present_in))
    else $error("d3cold wrong");
  AST_STRAP: assert property (
    $changed(lan_enable_out) && $past(resetn_in)
    |-> lan_enable_out == $past(flash_serial_in) && $past(live))
    else $error("lan enable off strap");

  COV_SERR: cover property ($rose(serr_oe_out));
  COV_PERR_TWO: cover property ((perr_oe_out && !perr_n_out) [*2]);
  COV_PME: cover property ($rose(pme_oe_out));
endmodule

bind pepc_top pepc_top_properties u_pepc_top_properties (.clk_sys_in, .resetn_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .power_good_in,
  .pci_rst_n_in, .aux_power_present_in, .addr_parity_err_in, .data_phase_in,
  .data_parity_err_in, .special_cycle_in, .wake_event_in, .flash_serial_in,
  .serr_oe_out, .perr_n_out, .perr_oe_out, .pme_oe_out, .lan_enable_out,
  .d3cold_support_out);
`default_nettype wire

// ---- verif/pepc_top_tb.sv ----
// Self-checking bench for the PCI error and power event block
`timescale 1ns/1ps
`default_nettype none
module pepc_top_tb;
  localparam logic [7:0] A_CTRL = pepc_pkg::PEPC_WAKE_CTRL_OFS;
  localparam logic [7:0] A_ST = pepc_pkg::PEPC_STATUS_OFS;
  localparam logic [7:0] A_INFO = pepc_pkg::PEPC_INFO_OFS;
  localparam logic [7:0] A_CNT = pepc_pkg::PEPC_ERRCNT_OFS;
  logic clk_sys_in = 1'b0, resetn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, power_good_in = 1'b0, pci_rst_n_in = 1'b0;
  logic aux_power_present_in = 1'b0, addr_parity_err_in = 1'b0, data_phase_in = 1'b0;
  logic data_parity_err_in = 1'b0, special_cycle_in = 1'b0, wake_event_in = 1'b0;
  logic strap_drive = 1'b1, strap_val = 1'b0, se;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, flash_serial_in, flash_pullup_en_out, serr_oe_out;
  logic perr_n_out, perr_oe_out, pme_oe_out, pci_float_out, core_reset_out;
  logic lan_enable_out, d3cold_support_out, serr_n_out, pme_n_out;
  int errors = 0, compares = 0;

  always #2 clk_sys_in = !clk_sys_in;

  pepc_top u_pepc_top (.clk_sys_in, .resetn_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .power_good_in,
    .pci_rst_n_in, .aux_power_present_in, .addr_parity_err_in, .data_phase_in,
    .data_parity_err_in, .special_cycle_in, .wake_event_in, .flash_serial_in,
    .flash_pullup_en_out, .serr_n_out, .serr_oe_out, .perr_n_out, .perr_oe_out,
    .pme_n_out, .pme_oe_out, .pci_float_out, .core_reset_out, .lan_enable_out,
    .d3cold_support_out);
  pepc_host_model u_pepc_host_model (.clk_sys_in, .flash_fitted_in(1'b0),
    .flash_bit_in(1'b0), .strap_drive_in(strap_drive), .strap_val_in(strap_val),
    .flash_pullup_en_in(flash_pullup_en_out), .flash_serial_out(flash_serial_in));

  task close_out;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Let the edge's updates land before sampling
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    if (pready_out !== 1'b1) begin
      errors++;
      close_out;
    end else begin
      rd = prdata_out;
      se = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask

  task wake;
    @(posedge clk_sys_in);
    wake_event_in <= 1'b1;
    @(posedge clk_sys_in);
    wake_event_in <= 1'b0;
  endtask

  task t_strap;
    @(posedge clk_sys_in);
    power_good_in <= 1'b1;
    pci_rst_n_in <= 1'b1;
    cyc(250);
    chk(lan_enable_out, 1'b0);
    apb(1'b0, A_INFO, 32'h0);
    chk(rd, 32'h12);
    @(posedge clk_sys_in);
    strap_drive <= 1'b0;
    pci_rst_n_in <= 1'b0;
    @(posedge clk_sys_in);
    pci_rst_n_in <= 1'b1;
    cyc(250);
    chk(lan_enable_out, 1'b1);
    $display("strap test done");
  endtask

  task t_regs;
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, A_CTRL, 32'hffff_ffff);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, 8'h10, 32'h0);
    chk(se, 1'b1);
    chk(rd, 32'h0);
    $display("register test done");
  endtask

  task t_pme;
    for (int e = 0; e < 4; e++) begin
      apb(1'b1, A_CTRL, 32'(e));
      wake;
      cyc(0);
      chk(pme_oe_out, e != 0);
      cyc(8);
      chk(pme_oe_out, e != 0);
      apb(1'b1, A_ST, 32'h1);
      cyc(2);
      chk(pme_oe_out, 1'b0);
    end
    apb(1'b1, A_CTRL, 32'h2);
    wake;
    apb(1'b1, A_CTRL, 32'h0);
    cyc(2);
    chk(pme_oe_out, 1'b0);
    apb(1'b1, A_ST, 32'h1);
    $display("wake test done");
  endtask

  task t_serr;
    @(posedge clk_sys_in);
    addr_parity_err_in <= 1'b1;
    @(posedge clk_sys_in);
    addr_parity_err_in <= 1'b0;
    cyc(0);
    chk(serr_oe_out, 1'b1);
    cyc(1);
    chk(serr_oe_out, 1'b0);
    apb(1'b0, A_ST, 32'h0);
    chk(rd, 32'h2);
    $display("system error test done");
  endtask

  task t_perr;
    @(posedge clk_sys_in);
    data_phase_in <= 1'b1;
    data_parity_err_in <= 1'b1;
    @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    data_phase_in <= 1'b0;
    data_parity_err_in <= 1'b0;
    cyc(0);
    chk(perr_oe_out, 1'b0);
    cyc(1);
    chk({perr_oe_out, perr_n_out}, 2'b10);
    cyc(1);
    chk({perr_oe_out, perr_n_out}, 2'b10);
    cyc(1);
    chk({perr_oe_out, perr_n_out}, 2'b11);
    cyc(1);
    chk({perr_oe_out, perr_n_out}, 2'b01);
    @(posedge clk_sys_in);
    data_phase_in <= 1'b1;
    data_parity_err_in <= 1'b1;
    special_cycle_in <= 1'b1;
    @(posedge clk_sys_in);
    data_phase_in <= 1'b0;
    data_parity_err_in <= 1'b0;
    special_cycle_in <= 1'b0;
    repeat (5) begin
      cyc(1);
      chk(perr_oe_out, 1'b0);
    end
    // Two errored phases and one address error so far, special cycle not counted
    apb(1'b0, A_ST, 32'h0);
    chk(rd, 32'h6);
    apb(1'b0, A_CNT, 32'h0);
    chk(rd, 32'h0002_0001);
    $display("parity error test done");
  endtask

  task t_reset;
    apb(1'b1, A_CTRL, 32'h1);
    wake;
    @(posedge clk_sys_in);
    pci_rst_n_in <= 1'b0;
    addr_parity_err_in <= 1'b1;
    @(posedge clk_sys_in);
    addr_parity_err_in <= 1'b0;
    cyc(1);
    chk({pci_float_out, pme_oe_out, serr_oe_out}, 3'b110);
    apb(1'b0, A_INFO, 32'h0);
    chk(rd, 32'h39);
    @(posedge clk_sys_in);
    pci_rst_n_in <= 1'b1;
    cyc(2);
    apb(1'b0, A_ST, 32'h0);
    chk(rd, 32'h1);
    @(posedge clk_sys_in);
    power_good_in <= 1'b0;
    cyc(2);
    chk({pci_float_out, core_reset_out, pme_oe_out}, 3'b110);
    @(posedge clk_sys_in);
    power_good_in <= 1'b1;
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask

  task t_levels;
    @(posedge clk_sys_in);
    aux_power_present_in <= 1'b1;
    cyc(1);
    chk(d3cold_support_out, 1'b1);
    // Strap window re-armed by the power cycle, so no valid sample yet
    apb(1'b0, A_INFO, 32'h0);
    chk(rd, 32'h15);
    @(posedge clk_sys_in);
    aux_power_present_in <= 1'b0;
    cyc(1);
    chk({d3cold_support_out, flash_pullup_en_out}, 2'b01);
    chk({serr_n_out, pme_n_out}, 2'b00);
    $display("level test done");
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    t_strap;
    t_regs;
    t_pme;
    t_serr;
    t_perr;
    t_reset;
    t_levels;
    close_out;
  end
endmodule
`default_nettype wire
